// *** logic/wdtio_top.v ***
/*
 Watchdog timer behind one write-only 8-bit I/O port.
 Assumes a one-cycle io write strobe with address and data valid with it,
 all synchronous to ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "wdtio_map.vh"

module wdtio_top #(
	parameter integer TICK_CYCLES = `WDTIO_TICK_CYCLES,
	parameter integer RST_CYCLES  = `WDTIO_RST_CYCLES
) (
	// Clock, reset, enable
	input  wire        ref_clk,
	input  wire        rst_n,
	input  wire        clk_en,
	// I/O write port
	input  wire [15:0] io_addr,
	input  wire [7:0]  io_wdata,
	input  wire        io_wr,
	// Responses
	output reg         sys_rst_out,
	output reg         irq9_out,
	output wire        wdt_active
);
	reg  [7:0] ctrl_r;
	reg  [5:0] elapsed_r;
	reg  [7:0] rst_cnt_r;
	reg        expired_r;
	wire       hit;
	wire       tick;
	wire       en;
	wire [5:0] period;

	assign hit    = io_wr && (io_addr == `WDTIO_PORT_ADDR); // R1
	assign en     = ctrl_r[`WDTIO_BIT_ENABLE]; // R5
	assign period = ctrl_r[`WDTIO_PERIOD_HI:`WDTIO_PERIOD_LO]; // R6 R9
	assign wdt_active = en;

	// Seconds counted once the current tick is taken
	function [5:0] sec_next;
		input [5:0] secs;
		begin
			sec_next = secs + 6'h01;
		end
	endfunction

	// Writes restart the second so a trigger gives a full period
	wdtio_prescale #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_pre (
		.ref_clk(ref_clk),
		.rst_n  (rst_n),
		.clk_en (clk_en),
		.clear  (hit), // R3 R12
		.tick   (tick)
	);

	always @(posedge ref_clk) begin
		if (!rst_n) begin
			ctrl_r      <= `WDTIO_CTRL_RESET; // R2
			elapsed_r   <= 6'h00;
			expired_r   <= 1'b0;
			rst_cnt_r   <= 8'h00;
			sys_rst_out <= 1'b0;
			irq9_out    <= 1'b0;
		end else if (clk_en) begin
			if (hit) begin
				ctrl_r    <= io_wdata; // R12
				elapsed_r <= 6'h00; // R3
				expired_r <= 1'b0;
				if (!io_wdata[`WDTIO_BIT_ENABLE]) begin
					irq9_out    <= 1'b0; // R10
					sys_rst_out <= 1'b0;
					rst_cnt_r   <= 8'h00;
				end else if (!io_wdata[`WDTIO_BIT_RESP])
					irq9_out <= 1'b0;
			end else if (en && !expired_r && tick) begin
				if (sec_next(elapsed_r) >= period) begin // R4 R7 R8 R9
					expired_r <= 1'b1;
					if (ctrl_r[`WDTIO_BIT_RESP]) begin
						sys_rst_out <= 1'b1;
						rst_cnt_r   <= RST_CYCLES[7:0]; // R13
					end else
						irq9_out <= 1'b1;
				end else
					elapsed_r <= sec_next(elapsed_r);
			end
			// Fixed-length reset pulse; only a disabling write may cut it short
			if (sys_rst_out && !(hit && !io_wdata[`WDTIO_BIT_ENABLE])) begin // R13
				if (rst_cnt_r <= 8'h01) begin
					sys_rst_out <= 1'b0;
					rst_cnt_r   <= 8'h00;
				end else
					rst_cnt_r <= rst_cnt_r - 8'h01;
			end
		end
	end
endmodule // wdtio_top
`default_nettype wire

// *** common/wdtio_map.vh ***
/*
 Constants for the I/O-port watchdog: port address, control byte fields,
 reset values and timing counts. Assumes inclusion by the watchdog logic only.
 // Function
 // R1 - Decode control register at port 0x214
 // R2 - Watchdog disabled after system reset
 // R3 - Trigger write clears elapsed counter
 // R4 - Timeout gives reset pulse or IRQ9
 // R5 - Bit 7 enables or disables watchdog
 // R6 - Bit 6 selects response; bits 5:0 period
 // R7 - 0xC8 resets after eight seconds
 // R8 - 0x88 raises IRQ9 after eight seconds
 // R9 - Period field counts whole seconds
 // R10 - Bit 7 clear disables, cancels pending response
 // R11 - Software retriggers within every period
 // R12 - New period adopted, counting restarts
 // R13 - Prescaled one-second tick, fixed reset pulse
*/
`ifndef WDTIO_MAP_VH
`define WDTIO_MAP_VH

`define WDTIO_PORT_ADDR    16'h0214
`define WDTIO_CTRL_RESET   8'h00
`define WDTIO_BIT_ENABLE   7
`define WDTIO_BIT_RESP     6
`define WDTIO_PERIOD_HI    5
`define WDTIO_PERIOD_LO    0
`define WDTIO_CLK_HZ       10000000
`define WDTIO_TICK_NS      1000000000
`define WDTIO_CLK_NS       100
`define WDTIO_TICK_CYCLES  (`WDTIO_TICK_NS / `WDTIO_CLK_NS)
`define WDTIO_RST_CYCLES   16

`endif

// *** logic/wdtio_prescale.v ***
/*
 One-second tick prescaler for the watchdog.
 Assumes ref_clk at the documented rate; clear restarts the second.
*/
`timescale 1ns/1ps
`default_nettype none
`include "wdtio_map.vh"

module wdtio_prescale #(
	parameter integer TICK_CYCLES = `WDTIO_TICK_CYCLES
) (
	// Clock and control
	input  wire ref_clk,
	input  wire rst_n,
	input  wire clk_en,
	input  wire clear,
	// Tick out
	output reg  tick
);
	reg [31:0] cnt_r;

	always @(posedge ref_clk) begin
		if (!rst_n) begin
			cnt_r <= 32'h0;
			tick  <= 1'b0;
		end else if (clk_en) begin
			if (clear) begin
				cnt_r <= 32'h0;
				tick  <= 1'b0;
			end else if (cnt_r == TICK_CYCLES - 1) begin // R13
				cnt_r <= 32'h0;
				tick  <= 1'b1;
			end else begin
				cnt_r <= cnt_r + 32'h1;
				tick  <= 1'b0;
			end
		end
	end
endmodule // wdtio_prescale
`default_nettype wire

// *** testbench/wdtio_checker.sv ***
/* Port watchdog checker; assumes tick 10 and pulse 4 cycles */
`timescale 1ns/1ps
`default_nettype none
module wdtio_checker #(parameter integer TICK_CYCLES = 10, RST_CYCLES = 4) (
	input wire logic        ref_clk, rst_n, clk_en, io_wr,
	input wire logic [15:0] io_addr,
	input wire logic [7:0]  io_wdata,
	input wire logic        sys_rst_out, irq9_out, wdt_active);
	wire wp = clk_en && io_wr && io_addr == 16'h0214;
	wire cut_wr = wp && !io_wdata[7];
	logic [7:0] pulse_cnt;
	// Length of the current reset pulse, counted in running cycles
	always @(posedge ref_clk) begin
		if (!rst_n)
			pulse_cnt <= 8'h00;
		else if (clk_en)
			pulse_cnt <= sys_rst_out ? pulse_cnt + 8'h01 : 8'h00;
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n || !clk_en);
	a_wr_en: assert property (wp |=> wdt_active == $past(io_wdata[7])) else $error("en");
	a_stray_wr: assert property (!wp |=> $stable(wdt_active)) else $error("stray");
	a_off_quiet: assert property (!wdt_active |-> !sys_rst_out && !irq9_out) else $error("off");
	a_off_clr: assert property (wp && !io_wdata[7] |=> !irq9_out && !sys_rst_out)
		else $error("clr");
	a_pulse_len: assert property ($fell(sys_rst_out) && !$past(cut_wr) |-> pulse_cnt == RST_CYCLES)
		else $error("len");
	a_irq_hold: assert property (irq9_out && !wp |=> irq9_out) else $error("irq");
	a_one_sec: assert property (wp && io_wdata == 8'hC1 |=> (!sys_rst_out)[*8] ##[1:5] sys_rst_out)
		else $error("sec");
	a_trig_calm: assert property (wp && io_wdata[7:6] == 2'b10 |=> (!irq9_out)[*8])
		else $error("trig");
	c_rst: cover property ($rose(sys_rst_out));
	c_irq: cover property ($rose(irq9_out));
	c_off: cover property (wp && !io_wdata[7]);
endmodule // wdtio_checker
bind wdtio_top wdtio_checker #(.TICK_CYCLES(TICK_CYCLES), .RST_CYCLES(RST_CYCLES)) chk_u (
	.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .io_wr(io_wr), .io_addr(io_addr),
	.io_wdata(io_wdata), .sys_rst_out(sys_rst_out), .irq9_out(irq9_out),
	.wdt_active(wdt_active));
`default_nettype wire

// *** testbench/tb_wdtio_top.sv ***
/* Bench for the port watchdog; short tick so timeouts fit the run */
`timescale 1ns/1ps
`default_nettype none
module tb_wdtio_top;
	logic        ref_clk = 0, rst_n = 0, clk_en = 1, io_wr = 0;
	logic [15:0] io_addr = 16'h0000;
	logic [7:0]  io_wdata = 8'h00;
	logic        sys_rst_out, irq9_out, wdt_active;
	int          err_total = 0, checks = 0, n;
	wdtio_top #(.TICK_CYCLES(10), .RST_CYCLES(4)) dut_u (
		.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .io_addr(io_addr),
		.io_wdata(io_wdata), .io_wr(io_wr), .sys_rst_out(sys_rst_out),
		.irq9_out(irq9_out), .wdt_active(wdt_active));
	always #50 ref_clk = ~ref_clk;
	task chk(input logic [7:0] s, e);
		checks++;
		if (s !== e) begin
			err_total++;
			$display("unexpected at %0t: %h not %h", $time, s, e);
		end
	endtask
	task cyc(input int k);
		repeat (k) @(posedge ref_clk);
		#1;
	endtask
	task w(input logic [15:0] a, input logic [7:0] d);
		cyc(1);
		{io_addr, io_wdata, io_wr} = {a, d, 1'b1};
		cyc(1);
		io_wr = 0;
	endtask
	task t_irq;
		w(16'h0214, 8'h88);
		chk(wdt_active, 1);
		cyc(75);
		chk(irq9_out, 0);
		cyc(40);
		chk(irq9_out, 1);
		w(16'h0214, 8'h00);
		chk({wdt_active, irq9_out}, 0);
	endtask
	task t_rst;
		w(16'h0214, 8'hC8);
		cyc(50);
		w(16'h0214, 8'hC8);
		cyc(75);
		chk(sys_rst_out, 0);
		repeat (20) if (!sys_rst_out) cyc(1);
		chk(sys_rst_out, 1);
		for (n = 0; sys_rst_out === 1'b1; n++) cyc(1);
		chk(8'(n), 4);
	endtask
	task t_misc;
		w(16'h0215, 8'h00);
		chk(wdt_active, 1);
		w(16'h0214, 8'hCF);
		w(16'h0214, 8'hC1);
		cyc(12);
		chk(sys_rst_out, 1);
		w(16'h0214, 8'h40);
		chk(sys_rst_out, 0);
	endtask
	task t_freeze;
		w(16'h0214, 8'h81);
		clk_en = 0;
		cyc(20);
		clk_en = 1;
		chk(irq9_out, 0);
		cyc(12);
		chk(irq9_out, 1);
		w(16'h0214, 8'h00);
		chk(irq9_out, 0);
	endtask
	task t_midrst;
		w(16'h0214, 8'hC1);
		rst_n = 0;
		cyc(2);
		rst_n = 1;
		chk({sys_rst_out, irq9_out, wdt_active}, 0);
		cyc(20);
		chk(sys_rst_out, 0);
	endtask
	task tally_and_finish;
		if (err_total == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		cyc(5);
		rst_n = 1;
		chk({sys_rst_out, irq9_out, wdt_active}, 0);
		t_irq;
		t_rst;
		t_misc;
		t_freeze;
		t_midrst;
		tally_and_finish;
	end
	initial begin
		#100us;
		err_total++;
		tally_and_finish;
	end
endmodule // tb_wdtio_top
`default_nettype wire
